// ===== hdl/ccpt_pkg.sv
// Purpose: shared constants and types
// Assumes: 32-bit Avalon data, one register a word
// Notes:   offsets, fields and reset values
package ccpt_pkg;
	// ------------
	// register byte offsets
	// ------------
	localparam logic [4:0] OFS_T2_CONTROL = 5'h00; // timer2_control
	localparam logic [4:0] OFS_T2_PERIOD  = 5'h04; // timer2_period
	localparam logic [4:0] OFS_T2_COUNT   = 5'h08; // timer2_count
	localparam logic [4:0] OFS_CC_CONTROL = 5'h0C; // capture_compare_control
	localparam logic [4:0] OFS_VAL_LOW    = 5'h10; // unit_value_low
	localparam logic [4:0] OFS_VAL_HIGH   = 5'h14; // unit_value_high
	localparam logic [4:0] OFS_IRQ_FLAGS  = 5'h18; // peripheral_irq_flags
	localparam logic [4:0] OFS_IRQ_ENA    = 5'h1C; // peripheral_irq_enables
	// ------------
	// fields and reset values
	// ------------
	localparam int         POST_LSB       = 3;        // post divide select lsb
	localparam int         RUN_BIT        = 2;        // period timer run bit
	localparam int         DUTY_LSB       = 4;        // duty low bits lsb
	localparam int         FLAG_UNIT      = 2;        // unit event flag position
	localparam int         FLAG_PERIOD    = 1;        // period match flag position
	localparam logic [7:0] T2CTL_MASK     = 8'h7F;    // top bit unimplemented
	localparam logic [7:0] CCCTL_MASK     = 8'h3F;    // top two bits unimplemented
	localparam logic [7:0] FLAG_MASK      = 8'h06;    // implemented flag bits
	localparam logic [7:0] PERIOD_RST     = 8'hFF;
	localparam logic [7:0] COUNT_RST      = 8'h00;
	localparam logic [7:0] CTL_RST        = 8'h00;
	localparam logic [3:0] EDGE_DIV4      = 4'h3;     // last count of /4
	localparam logic [3:0] EDGE_DIV16     = 4'hF;     // last count of /16
	localparam logic [3:0] PRE_DIV4       = 4'h3;
	localparam logic [3:0] PRE_DIV16      = 4'hF;
	// ------------
	// unit mode codes
	// ------------
	localparam logic [3:0] MODE_OFF       = 4'h0;
	localparam logic [3:0] MODE_TOGGLE    = 4'h2;
	localparam logic [3:0] MODE_CAP_FALL  = 4'h4;
	localparam logic [3:0] MODE_CAP_RISE  = 4'h5;
	localparam logic [3:0] MODE_CAP_R4    = 4'h6;
	localparam logic [3:0] MODE_CAP_R16   = 4'h7;
	localparam logic [3:0] MODE_SET       = 4'h8;
	localparam logic [3:0] MODE_CLEAR     = 4'h9;
	localparam logic [3:0] MODE_SOFT      = 4'hA;
	localparam logic [3:0] MODE_SPECIAL   = 4'hB;

	// avalon request bundle
	typedef struct packed {
		logic [4:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
	} ccpt_req_t;
endpackage : ccpt_pkg

// ===== hdl/ccpt_period_timer.sv
// Purpose: eight-bit period timer
// Assumes: one clock, sync reset
// Notes:   one pulse per postscaled match
`timescale 1ns/1ps
`default_nettype none
module ccpt_period_timer (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic [7:0] control,     // timer control value
	input  wire logic [7:0] period,      // period limit
	input  wire logic       count_wr,    // software writes the count
	input  wire logic [7:0] count_wdata, // value written to the count
	input  wire logic       control_wr,  // software writes the control
	output logic      [7:0] count,       // current count
	output logic            match_tick,  // postscaled match pulse
	output logic            wave_tick    // raw count increment strobe
);
	import ccpt_pkg::*;

	logic [3:0] pre_q;   // prescale counter
	logic [3:0] post_q;  // postscale counter
	logic [3:0] pre_end; // last prescale count
	logic       inc;     // count advances this cycle
	logic       hit;     // count equals period at increment

	// prescale terminal: /1, /4, /16 when upper bit set
	always_comb begin
		if (control[1])
			pre_end = PRE_DIV16; // see R3
		else if (control[0])
			pre_end = PRE_DIV4; // see R3
		else
			pre_end = 4'h0; // see R3
	end

	assign inc       = control[RUN_BIT] && (pre_q == pre_end); // see R2
	assign hit       = inc && (count == period);
	assign wave_tick = inc;

	// prescale counter, cleared by count or control writes
	always_ff @(posedge clk) begin
		if (!rst_b || count_wr || control_wr)
			pre_q <= 4'h0; // see R21
		else if (control[RUN_BIT])
			pre_q <= (pre_q == pre_end) ? 4'h0 : pre_q + 4'h1;
	end

	// count register: wraps to zero on the increment after a match
	always_ff @(posedge clk) begin
		if (!rst_b)
			count <= COUNT_RST; // see R4
		else if (count_wr)
			count <= count_wdata;
		else if (hit)
			count <= 8'h00; // see R20
		else if (inc)
			count <= count + 8'h01; // see R20
	end

	// postscaler divides matches by select plus one
	always_ff @(posedge clk) begin
		if (!rst_b || count_wr || control_wr) begin
			post_q     <= 4'h0; // see R21
			match_tick <= 1'b0;
		end else begin
			match_tick <= 1'b0;
			if (hit) begin
				if (post_q == control[POST_LSB +: 4]) begin
					post_q     <= 4'h0;
					match_tick <= 1'b1; // see R1
				end else
					post_q <= post_q + 4'h1;
			end
		end
	end
endmodule : ccpt_period_timer
`default_nettype wire

// ===== hdl/ccpt_edge_sync.sv
// Purpose: pin synchroniser and edge detector
// Assumes: pin changes at any time
// Notes:   first stage read only by second
`timescale 1ns/1ps
`default_nettype none
module ccpt_edge_sync (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic pin,   // raw pin level
	output logic      rise,  // one-cycle rising edge pulse
	output logic      fall   // one-cycle falling edge pulse
);
	logic meta_q; // first stage
	logic sync_q; // second stage
	logic last_q; // previous synchronised level

	// synchronise then compare against the previous level
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= pin; // see R24
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign rise = sync_q && !last_q; // see R24
	assign fall = !sync_q && last_q;
endmodule : ccpt_edge_sync
`default_nettype wire

// ===== hdl/ccpt_top.sv
// Purpose: capture/compare/waveform unit with period timer
// Assumes: counter from outside; inputs synchronous except the pin, which is synchronised
// Notes:   waitrequest low the cycle after a request
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1 - postscaler divides matches by select plus one
// R2 - run bit starts and halts period timer
// R3 - prescaler divides by 1, 4 or 16
// R4 - reset: period all ones, count, control zero
// R5 - capture/compare use counter, waveform uses timer
// R6 - duty low bits used only in waveform
// R7 - mode zero switches unit off, resets state
// R8 - reserved modes perform no function
// R9 - toggle mode inverts pin, sets flag
// R10 - set/clear modes drive pin, set flag
// R11 - soft mode sets flag, pin unchanged
// R12 - special mode resets counter, starts conversion
// R13 - upper two mode bits select waveform
// R14 - capture on falling, rising, 4th, 16th edges
// R15 - capture copies full sixteen-bit count
// R16 - capture sets flag; software clears it
// R17 - new capture overwrites without overrun
// R18 - edge detector watches pin even when driven
// R19 - host sets pin input before capture
// R20 - timer counts to period, wraps, advances postscaler
// R21 - count/control writes clear pre/postscalers
// R22 - compare value pair against counter continuously
// R23 - edge prescaler cleared outside capture modes
// R24 - pin synchronised before edge detection
module ccpt_top (
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	input  wire ccpt_pkg::ccpt_req_t  avs_req,          // avalon request bundle
	output logic                      avs_waitrequest,  // low when answer ready
	output logic               [31:0] avs_readdata,     // read data
	input  wire logic          [15:0] counter_value,    // sixteen-bit counter
	input  wire logic                 unit_pin_in,      // pin level as seen
	input  wire logic                 converter_enable, // converter is enabled
	output logic                      unit_pin_out,     // unit output latch
	output logic                      counter_reset,    // pulse: reset counter
	output logic                      conversion_start, // pulse: start conversion
	output logic                      irq               // enabled flag pending
);
	import ccpt_pkg::*;

	// ------------
	// registers
	// ------------
	logic [7:0] t2_control_q;   // timer control
	logic [7:0] t2_period_q;    // period limit
	logic [7:0] cc_control_q;   // unit control
	logic [7:0] value_low_q;    // value low byte
	logic [7:0] value_high_q;   // value high byte
	logic [7:0] flags_q;        // event flags
	logic [7:0] enables_q;      // event enables
	logic       ack_q;          // answer given this cycle
	logic [3:0] edge_cnt_q;     // capture edge prescale counter
	logic [7:0] wave_dup_q;     // latched duty high bits
	logic [1:0] wave_low_q;     // latched duty low bits
	logic [1:0] wave_frac_q;    // sub-count for ten-bit duty
	logic       match_q;        // previous compare match level

	// ------------
	// derived signals
	// ------------
	logic       req;            // any request pending
	logic       take;           // request accepted at this edge
	logic       wr_t2ctl;       // control write strobe
	logic       wr_count;       // count write strobe
	logic [7:0] count;          // period timer count
	logic       match_tick;     // postscaled match pulse
	logic       wave_tick;      // timer increment pulse
	logic       pin_rise;       // synchronised rising edge
	logic       pin_fall;       // synchronised falling edge
	logic [3:0] mode;           // unit mode select
	logic       capture_mode;   // unit in a capture mode
	logic       compare_mode;   // unit in a compare mode
	logic       wave_mode;      // unit in waveform mode
	logic       cap_event;      // selected capture event
	logic       cmp_event;      // rising edge of compare match
	logic       unit_set;       // unit flag set this cycle
	logic       flag_wr;        // flag register written
	logic [9:0] wave_pos;       // ten-bit waveform position
	logic [7:0] rd_mux;         // selected read byte

	// byte write helper
	function automatic logic hit_wr(input ccpt_req_t r, input logic [4:0] ofs);
		hit_wr = r.write && (r.address == ofs);
	endfunction : hit_wr

	assign req          = avs_req.read || avs_req.write;
	assign take         = req && ack_q;
	assign wr_t2ctl     = take && hit_wr(avs_req, OFS_T2_CONTROL);
	assign wr_count     = take && hit_wr(avs_req, OFS_T2_COUNT);
	assign flag_wr      = take && hit_wr(avs_req, OFS_IRQ_FLAGS);
	assign mode         = cc_control_q[3:0];
	assign wave_mode    = (mode[3:2] == 2'b11); // see R13
	assign capture_mode = (mode[3:2] == 2'b01);
	assign compare_mode = (mode == MODE_TOGGLE) || (mode[3:2] == 2'b10); // see R8

	// ------------
	// sub-blocks
	// ------------
	ccpt_period_timer u_timer (
		.clk         (clk),
		.rst_b       (rst_b),
		.control     (t2_control_q),
		.period      (t2_period_q),
		.count_wr    (wr_count),
		.count_wdata (avs_req.writedata[7:0]),
		.control_wr  (wr_t2ctl),
		.count       (count),
		.match_tick  (match_tick),
		.wave_tick   (wave_tick)
	);

	ccpt_edge_sync u_sync (
		.clk   (clk),
		.rst_b (rst_b),
		.pin   (unit_pin_in), // see R18
		.rise  (pin_rise),
		.fall  (pin_fall)
	);

	// ------------
	// bus handshake
	// ------------

	// one wait cycle, then acknowledge for one cycle
	always_ff @(posedge clk) begin
		if (!rst_b)
			ack_q <= 1'b0;
		else
			ack_q <= req && !ack_q;
	end

	// waitrequest high except on the acknowledge cycle
	always_ff @(posedge clk) begin
		if (!rst_b)
			avs_waitrequest <= 1'b1;
		else
			avs_waitrequest <= !(req && !ack_q);
	end

	// read multiplexer; unmapped reads give zero
	always_comb begin
		unique case (avs_req.address)
			OFS_T2_CONTROL: rd_mux = t2_control_q & T2CTL_MASK; // see R4
			OFS_T2_PERIOD:  rd_mux = t2_period_q;
			OFS_T2_COUNT:   rd_mux = count;
			OFS_CC_CONTROL: rd_mux = cc_control_q & CCCTL_MASK;
			OFS_VAL_LOW:    rd_mux = value_low_q;
			OFS_VAL_HIGH:   rd_mux = value_high_q;
			OFS_IRQ_FLAGS:  rd_mux = flags_q;
			OFS_IRQ_ENA:    rd_mux = enables_q;
			default:        rd_mux = 8'h00;
		endcase
	end

	// read data registered alongside the acknowledge
	always_ff @(posedge clk) begin
		if (!rst_b)
			avs_readdata <= 32'h0000_0000;
		else if (req && !ack_q && avs_req.read)
			avs_readdata <= {24'h00_0000, rd_mux};
	end

	// ------------
	// software registers
	// ------------

	// timer control and period
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			t2_control_q <= CTL_RST; // see R4
			t2_period_q  <= PERIOD_RST; // see R4
		end else begin
			if (wr_t2ctl)
				t2_control_q <= avs_req.writedata[7:0] & T2CTL_MASK;
			if (take && hit_wr(avs_req, OFS_T2_PERIOD))
				t2_period_q <= avs_req.writedata[7:0];
		end
	end

	// unit control and enables
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cc_control_q <= CTL_RST;
			enables_q    <= CTL_RST;
		end else begin
			if (take && hit_wr(avs_req, OFS_CC_CONTROL))
				cc_control_q <= avs_req.writedata[7:0] & CCCTL_MASK;
			if (take && hit_wr(avs_req, OFS_IRQ_ENA))
				enables_q <= avs_req.writedata[7:0] & FLAG_MASK;
		end
	end

	// value pair: capture overwrites, software may write either byte
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			value_low_q  <= 8'h00;
			value_high_q <= 8'h00;
		end else if (cap_event) begin
			value_low_q  <= counter_value[7:0]; // see R15, R17
			value_high_q <= counter_value[15:8]; // see R15
		end else begin
			if (take && hit_wr(avs_req, OFS_VAL_LOW))
				value_low_q <= avs_req.writedata[7:0];
			if (take && hit_wr(avs_req, OFS_VAL_HIGH))
				value_high_q <= avs_req.writedata[7:0];
		end
	end

	// ------------
	// capture
	// ------------

	// edge prescale counter for every 4th and 16th rising edge
	always_ff @(posedge clk) begin
		if (!rst_b || !capture_mode)
			edge_cnt_q <= 4'h0; // see R23
		else if (pin_rise && (mode == MODE_CAP_R4 || mode == MODE_CAP_R16)) begin
			if ((mode == MODE_CAP_R4 && edge_cnt_q >= EDGE_DIV4) || edge_cnt_q == EDGE_DIV16)
				edge_cnt_q <= 4'h0;
			else
				edge_cnt_q <= edge_cnt_q + 4'h1;
		end
	end

	// selected capture event from mode and edge
	always_comb begin
		unique case (mode)
			MODE_CAP_FALL: cap_event = pin_fall; // see R14
			MODE_CAP_RISE: cap_event = pin_rise; // see R14
			MODE_CAP_R4:   cap_event = pin_rise && (edge_cnt_q >= EDGE_DIV4); // see R14
			MODE_CAP_R16:  cap_event = pin_rise && (edge_cnt_q == EDGE_DIV16); // see R14
			default:       cap_event = 1'b0;
		endcase
	end

	// ------------
	// compare
	// ------------

	// match is acted on once as it becomes true
	assign cmp_event = compare_mode && ({value_high_q, value_low_q} == counter_value) && !match_q; // see R22, R5

	// previous match level, cleared when unit off
	always_ff @(posedge clk) begin
		if (!rst_b || mode == MODE_OFF)
			match_q <= 1'b0; // see R7
		else
			match_q <= compare_mode && ({value_high_q, value_low_q} == counter_value);
	end

	// special event pulses
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			counter_reset    <= 1'b0;
			conversion_start <= 1'b0;
		end else begin
			counter_reset    <= cmp_event && (mode == MODE_SPECIAL); // see R12
			conversion_start <= cmp_event && (mode == MODE_SPECIAL) && converter_enable; // see R12
		end
	end

	// ------------
	// waveform generation on the period timer
	// ------------

	// duty reloaded at each period wrap; fraction counts sub-steps
	always_ff @(posedge clk) begin
		if (!rst_b || !wave_mode) begin
			wave_dup_q  <= 8'h00;
			wave_low_q  <= 2'b00;
			wave_frac_q <= 2'b00;
		end else begin
			wave_frac_q <= wave_frac_q + 2'b01;
			if (wave_tick && count == t2_period_q) begin
				wave_dup_q  <= value_low_q; // see R6
				wave_low_q  <= cc_control_q[DUTY_LSB +: 2]; // see R6
				wave_frac_q <= 2'b00;
			end
		end
	end

	assign wave_pos = {count, wave_frac_q};

	// output latch per mode
	always_ff @(posedge clk) begin
		if (!rst_b || mode == MODE_OFF)
			unit_pin_out <= 1'b0; // see R7
		else if (wave_mode)
			unit_pin_out <= (wave_pos < {wave_dup_q, wave_low_q}); // see R5, R13
		else if (cmp_event) begin
			unique case (mode)
				MODE_TOGGLE: unit_pin_out <= !unit_pin_out; // see R9
				MODE_SET:    unit_pin_out <= 1'b1; // see R10
				MODE_CLEAR:  unit_pin_out <= 1'b0; // see R10
				default:     unit_pin_out <= unit_pin_out; // see R11
			endcase
		end
	end

	// ------------
	// flags and interrupt
	// ------------

	assign unit_set = cap_event || cmp_event; // see R16, R9, R10, R11

	// sticky flags: hardware sets, software writes; set wins
	always_ff @(posedge clk) begin
		if (!rst_b)
			flags_q <= 8'h00;
		else begin
			if (flag_wr)
				flags_q <= avs_req.writedata[7:0] & FLAG_MASK; // see R16
			if (unit_set)
				flags_q[FLAG_UNIT] <= 1'b1; // see R16
			if (match_tick)
				flags_q[FLAG_PERIOD] <= 1'b1; // see R20
		end
	end

	// interrupt request from enabled flags
	always_ff @(posedge clk) begin
		if (!rst_b)
			irq <= 1'b0;
		else
			irq <= |(flags_q & enables_q);
	end
endmodule : ccpt_top
`default_nettype wire

// ===== verification/ccpt_monitor.sv
// Purpose: port checks on the unit
// Assumes: one clock, sync reset
// Notes:   bound to the top module
`timescale 1ns/1ps
`default_nettype none
module ccpt_monitor (
	input wire logic                clk,
	input wire logic                rst_b,
	input wire ccpt_pkg::ccpt_req_t avs_req,
	input wire logic                avs_waitrequest,
	input wire logic [31:0]         avs_readdata,
	input wire logic [15:0]         counter_value,
	input wire logic                unit_pin_in,
	input wire logic                converter_enable,
	input wire logic                unit_pin_out,
	input wire logic                counter_reset,
	input wire logic                conversion_start,
	input wire logic                irq
);
	import ccpt_pkg::*;
	// ------------
	// all checks share the one clock and reset
	// ------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	// outputs leave reset idle
	property p_reset_idle;
		$rose(rst_b) |-> avs_waitrequest && !unit_pin_out && !irq && !counter_reset;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
	// unimplemented upper lanes read zero
	property p_rdata_top;
		!avs_waitrequest && avs_req.read |-> avs_readdata[31:8] == 24'h000000;
	endproperty
	a_rdata_top: assert property (p_rdata_top) else $error("read data upper lanes not zero");
	// the answer stands one cycle only
	property p_wait_one;
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
	// a pending request is answered within two edges
	property p_wait_bound;
		(avs_req.read || avs_req.write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest;
	endproperty
	a_wait_bound: assert property (p_wait_bound) else $error("request not answered");
	// no answer without a request
	property p_wait_cause;
		$fell(avs_waitrequest) |-> $past(avs_req.read || avs_req.write);
	endproperty
	a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
	// counter reset is a single-cycle pulse
	property p_special_pulse;
		counter_reset |=> !counter_reset;
	endproperty
	a_special_pulse: assert property (p_special_pulse) else $error("counter reset pulse too long");
	// conversion only starts with a special event
	property p_conv_needs_reset;
		conversion_start |-> counter_reset;
	endproperty
	a_conv_needs_reset: assert property (p_conv_needs_reset) else $error("conversion without event");
	// the special event leaves the pin alone
	property p_special_pin;
		counter_reset |-> $stable(unit_pin_out);
	endproperty
	a_special_pin: assert property (p_special_pin) else $error("pin moved on special event");
	// switching the unit off forces the pin low
	property p_off_pin;
		avs_req.write && !avs_waitrequest && avs_req.address == OFS_CC_CONTROL
			&& avs_req.writedata[3:0] == MODE_OFF |-> ##2 !unit_pin_out;
	endproperty
	a_off_pin: assert property (p_off_pin) else $error("pin not low after unit off");
endmodule : ccpt_monitor

bind ccpt_top ccpt_monitor u_monitor (
	.clk(clk), .rst_b(rst_b), .avs_req(avs_req), .avs_waitrequest(avs_waitrequest),
	.avs_readdata(avs_readdata), .counter_value(counter_value), .unit_pin_in(unit_pin_in),
	.converter_enable(converter_enable), .unit_pin_out(unit_pin_out), .counter_reset(counter_reset),
	.conversion_start(conversion_start), .irq(irq)
);
`default_nettype wire

// ===== verification/ccpt_far_model.sv
// Purpose: outside counter and event pin
// Assumes: counter frozen unless loaded or cleared by a special event
// Notes:   pin follows the bench
`timescale 1ns/1ps
`default_nettype none
module ccpt_far_model (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        counter_reset, // special event from the unit
	input  wire logic        load,          // bench loads the counter
	input  wire logic [15:0] load_val,      // value to load
	input  wire logic        pin_cmd,       // bench pin level
	output logic      [15:0] counter_value, // time base for capture/compare
	output logic             pin_level      // level seen on the unit pin
);
	// counter: special event clears it, else bench load wins
	always_ff @(posedge clk) begin
		if (!rst_b)
			counter_value <= 16'h0000;
		else if (counter_reset)
			counter_value <= 16'h0000;
		else if (load)
			counter_value <= load_val;
	end
	// pin is always an input here, driven from outside
	assign pin_level = pin_cmd;
endmodule : ccpt_far_model
`default_nettype wire

// ===== verification/ccpt_top_test.sv
// Purpose: self-checking bench
// Assumes: far model gives counter and pin
// Notes:   flags polled over the bus
`timescale 1ns/1ps
`default_nettype none
module ccpt_top_test;
	import ccpt_pkg::*;
	// ------------
	// signals
	// ------------
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	ccpt_req_t   req = '0;
	logic        wreq, pin, pout, cres, cstart, irq;
	logic [31:0] rd, rdata;
	logic [15:0] cnt;
	logic        load = 1'b0;
	logic [15:0] load_val = 16'h0000;
	logic        pin_cmd = 1'b0;
	logic        conv_en = 1'b1;
	logic        conv_seen = 1'b0;
	int          n_errors = 0;
	int          total_checks = 0;
	int          cyc = 0;
	logic [3:0]  cm [7] = '{4'h8, 4'h9, 4'h2, 4'hA, 4'hB, 4'h1, 4'h3}; // compare mode table
	logic        cp [7] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1}; // pin after match
	logic        cf [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0}; // flag after match
	logic [1:0]  mp [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h1};
	logic [3:0]  mq [6] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'hF, 4'h2};
	logic [4:0]  ro [6] = '{OFS_T2_CONTROL, OFS_T2_PERIOD, OFS_T2_COUNT, OFS_CC_CONTROL, OFS_IRQ_FLAGS, OFS_IRQ_ENA};
	logic [7:0]  rv [6] = '{CTL_RST, PERIOD_RST, COUNT_RST, 8'h00, 8'h00, 8'h00};

	always #12.5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	always @(posedge clk) if (cstart === 1'b1) conv_seen <= 1'b1;

	ccpt_top u_dut (.clk(clk), .rst_b(rst_b), .avs_req(req), .avs_waitrequest(wreq), .avs_readdata(rd),
		.counter_value(cnt), .unit_pin_in(pin), .converter_enable(conv_en), .unit_pin_out(pout),
		.counter_reset(cres), .conversion_start(cstart), .irq(irq));
	ccpt_far_model u_far (.clk(clk), .rst_b(rst_b), .counter_reset(cres), .load(load), .load_val(load_val),
		.pin_cmd(pin_cmd), .counter_value(cnt), .pin_level(pin));
	// ------------
	// tasks
	// ------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// one Avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		req <= '{address: a, read: !wr, write: wr, writedata: {24'h000000, d}};
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 50);
		if (n >= 50) check("bus answer", 32'h0, 32'h1);
		rdata = rd;
		req <= '0;
	endtask : bus
	task automatic expect_reg(input string what, input logic [4:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		check(what, {24'h000000, e}, rdata);
	endtask : expect_reg
	task automatic load_counter(input logic [15:0] v);
		@(posedge clk);
		load <= 1'b1;
		load_val <= v;
		@(posedge clk);
		load <= 1'b0;
	endtask : load_counter
	task automatic pin_to(input logic v);
		pin_cmd <= v;
		repeat (6) @(posedge clk);
	endtask : pin_to
	task automatic poll_period;
		int k;
		k = 0;
		do begin
			bus(1'b0, OFS_IRQ_FLAGS, 8'h00);
			k++;
		end while (rdata[FLAG_PERIOD] !== 1'b1 && k < 200);
	endtask : poll_period
	// clocks between two period flags against prescale and postscale
	task automatic measure(input logic [1:0] pre, input logic [3:0] post);
		int exp, t0, d;
		exp = 16 * ((pre == 2'h0) ? 1 : (pre == 2'h1) ? 4 : 16) * (post + 1);
		bus(1'b1, OFS_T2_CONTROL, {1'b0, post, 1'b1, pre});
		bus(1'b1, OFS_IRQ_FLAGS, 8'h00);
		poll_period();
		t0 = cyc;
		bus(1'b1, OFS_IRQ_FLAGS, 8'h00);
		poll_period();
		d = cyc - t0;
		if (d > exp - 4 && d < exp + 4) d = exp;
		check("period flag spacing", exp, d);
	endtask : measure
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : give_verdict
	// ------------
	// watchdog and tests
	// ------------
	initial begin
		#1500000;
		n_errors++;
		give_verdict();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 6; i++) expect_reg("reset value", ro[i], rv[i]);
		bus(1'b1, OFS_T2_CONTROL, 8'hFF);
		expect_reg("timer control mask", OFS_T2_CONTROL, 8'h7F);
		bus(1'b1, OFS_T2_CONTROL, 8'h00);
		bus(1'b1, OFS_T2_COUNT, 8'h05);
		repeat (20) @(posedge clk);
		expect_reg("halted count", OFS_T2_COUNT, 8'h05);
		bus(1'b1, OFS_T2_CONTROL, 8'h78);
		expect_reg("count after control write", OFS_T2_COUNT, 8'h05);
		$display("test registers done");
		bus(1'b1, OFS_T2_PERIOD, 8'h0F);
		for (int i = 0; i < 6; i++) measure(mp[i], mq[i]);
		bus(1'b1, OFS_T2_CONTROL, 8'h00);
		$display("test period timer done");
		for (int m = 4; m < 8; m++) begin
			int n;
			n = (m == 6) ? 4 : (m == 7) ? 16 : 1;
			pin_to(1'b0);
			bus(1'b1, OFS_CC_CONTROL, 8'h00);
			bus(1'b1, OFS_CC_CONTROL, {4'h0, m[3:0]});
			load_counter({8'h5A, 4'hC, m[3:0]});
			bus(1'b1, OFS_IRQ_FLAGS, 8'h00);
			repeat (n - 1) begin
				pin_to(1'b1);
				pin_to(1'b0);
			end
			if (m == 4) pin_to(1'b1);
			expect_reg("flags before event", OFS_IRQ_FLAGS, 8'h00);
			pin_to(m != 4);
			expect_reg("captured low", OFS_VAL_LOW, {4'hC, m[3:0]});
			expect_reg("captured high", OFS_VAL_HIGH, 8'h5A);
			expect_reg("flags after event", OFS_IRQ_FLAGS, 8'h04);
		end
		bus(1'b1, OFS_IRQ_ENA, 8'h04);
		repeat (3) @(posedge clk);
		check("irq enabled", 32'h1, {31'h0, irq});
		bus(1'b1, OFS_IRQ_ENA, 8'h00);
		bus(1'b1, OFS_IRQ_FLAGS, 8'h00);
		expect_reg("flags cleared", OFS_IRQ_FLAGS, 8'h00);
		$display("test capture done");
		bus(1'b1, OFS_CC_CONTROL, 8'h00);
		bus(1'b1, OFS_VAL_LOW, 8'h40);
		bus(1'b1, OFS_VAL_HIGH, 8'h12);
		load_counter(16'h0000);
		for (int i = 0; i < 7; i++) begin
			bus(1'b1, OFS_CC_CONTROL, {4'h0, cm[i]});
			bus(1'b1, OFS_IRQ_FLAGS, 8'h00);
			load_counter(16'h1240);
			repeat (4) @(posedge clk);
			check("pin after match", {31'h0, cp[i]}, {31'h0, pout});
			if (cm[i] == MODE_SPECIAL) begin
				check("counter after event", 32'h0, {16'h0000, cnt});
				check("conversion started", 32'h1, {31'h0, conv_seen});
			end
			expect_reg("flag after match", OFS_IRQ_FLAGS, {5'h00, cf[i], 2'h0});
			load_counter(16'h0000);
		end
		bus(1'b1, OFS_CC_CONTROL, 8'h00);
		repeat (3) @(posedge clk);
		check("pin after off", 32'h0, {31'h0, pout});
		$display("test compare done");
		bus(1'b1, OFS_T2_PERIOD, 8'h03);
		bus(1'b1, OFS_T2_CONTROL, 8'h04);
		bus(1'b1, OFS_VAL_LOW, 8'hFF);
		bus(1'b1, OFS_CC_CONTROL, 8'h3F);
		repeat (40) @(posedge clk);
		check("wave full duty", 32'h1, {31'h0, pout});
		bus(1'b1, OFS_VAL_LOW, 8'h00);
		bus(1'b1, OFS_CC_CONTROL, 8'h0C);
		repeat (40) @(posedge clk);
		check("wave zero duty", 32'h0, {31'h0, pout});
		$display("test waveform done");
		give_verdict();
	end
endmodule : ccpt_top_test
`default_nettype wire
